/* hdl/lca_learn_cascade.sv */
// Purpose: learn command, next-free pointer, fullness chain and cascade arbitration
// Assumes: neighbours and host share CLK_I; search array and comparands live outside
// Notes: single device view of a depth-cascaded table
`timescale 1ns/1ps
module lca_learn_cascade #(
  parameter int PTR_W = 14
) (
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_I,
  // host instruction port
  input wire logic [lca_pkg::CMD_W-1:0] CMD_I,
  input wire logic COMMAND_VALID_I,
  // register port
  input wire logic [3:0] REG_ADDR_I,
  input wire logic [31:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [31:0] REG_RDATA_O,
  // programmed data-array writes of the occupancy bit
  input wire logic ARRAY_WR_I,
  input wire logic [PTR_W-1:0] ARRAY_ADDR_I,
  input wire logic ARRAY_OCC_I,
  // own search result, valid in stage 3 after the second command cycle
  input wire logic SEARCH_HIT_I,
  input wire logic [PTR_W-1:0] SEARCH_INDEX_I,
  // learn write into the data array
  output logic CAM_WR_O,
  output logic [PTR_W-1:0] CAM_ADDR_O,
  output logic [3:0] CAM_PAIR_O,
  output logic CAM_WIDE_O,
  // fullness chain
  input wire logic FULL_IN_I,
  output logic [1:0] FULL_OUT_O,
  output logic TABLE_FULL_O,
  // hit cascade
  input wire logic [6:0] LOCAL_HIT_IN_I,
  output logic [1:0] LOCAL_HIT_OUT_O,
  output logic [2:0] BLOCK_HIT_OUT_O,
  output logic BLOCK_HIT_OE_O,
  // shared associative-data memory bus
  output logic [lca_pkg::MEM_ADDR_W-1:0] MEMORY_ADDRESS_BUS_O,
  output logic MEM_CE_N_O,
  output logic MEM_WE_N_O,
  output logic MEM_BUS_OE_O,
  output logic MEM_OE_N_O,
  output logic MEM_OE_N_OE_O,
  // shared result flags
  output logic RESULT_VALID_FLAG_O,
  output logic HIT_FLAG_O,
  output logic RESULT_FLAG_OE_O
);
  localparam int DEPTH = 1 << PTR_W;
  localparam int PAD = lca_pkg::IDX_W - PTR_W;

  logic [DEPTH-1:0] occ_q;
  logic [PTR_W:0] cnt_q;
  logic [PTR_W-1:0] free_q;
  lca_pkg::lca_scan_t scan_q;
  logic full_q, wide_q, phase_q;
  logic [2:0] csel_q;
  logic [3:0] pair_q;
  logic [lca_pkg::CFG_W-1:0] cfg_q;
  logic [6:1] li_q, lw_q, sp_q;
  logic [2:0] cp_q [1:6];
  logic [PTR_W-1:0] lad_q [1:6];
  logic hit_q, uhit_q;
  logic [PTR_W-1:0] idx_q;

  wire [1:0] tsize = cfg_q[lca_pkg::CFG_TSIZE_LSB +: 2];
  wire dflt = cfg_q[lca_pkg::CFG_DFLT_BIT];
  wire last = cfg_q[lca_pkg::CFG_LAST_BIT];
  wire [lca_pkg::ID_W-1:0] dev_id = cfg_q[lca_pkg::CFG_ID_LSB +: lca_pkg::ID_W];

  // instructions are two cycles; phase tells the second from the first
  wire second = COMMAND_VALID_I && phase_q;
  wire learn2 = second && (CMD_I[1:0] == lca_pkg::OP_LEARN);
  wire srch2 = second && (CMD_I[1:0] == lca_pkg::OP_SEARCH);

  // 136-bit learns start on an even entry
  wire [PTR_W-1:0] base = CMD_I[6] ? {free_q[PTR_W-1:1], 1'b0} : free_q;
  wire [PTR_W-1:0] odd = {base[PTR_W-1:1], 1'b1};
  wire base_busy = occ_q[base] || (CMD_I[6] && occ_q[odd]);
  wire win_learn = learn2 && FULL_IN_I && !full_q && !base_busy;
  wire tfull = full_q && FULL_IN_I;

  logic [2:0] lm1, lm2;
  always_comb begin
    case (tsize)
      lca_pkg::TSIZE_ONE: lm1 = lca_pkg::LAT_ONE - 3'h1;
      lca_pkg::TSIZE_BLK: lm1 = lca_pkg::LAT_BLK - 3'h1;
      default: lm1 = lca_pkg::LAT_MULTI - 3'h1;
    endcase
    lm2 = lm1 - 3'h1;
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      phase_q <= 1'b0;
    end else if (COMMAND_VALID_I) begin
      phase_q <= !phase_q;
    end else begin
      phase_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      csel_q <= 3'h0;
      pair_q <= 4'h0;
    end else if (COMMAND_VALID_I && !phase_q) begin
      csel_q <= CMD_I[8:6];
      pair_q <= CMD_I[5:2];
    end
  end

  // occupancy bits and their count
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      occ_q <= '0;
      cnt_q <= '0;
    end else if (win_learn) begin
      occ_q[base] <= 1'b1;
      if (CMD_I[6]) begin
        occ_q[odd] <= 1'b1;
      end
      cnt_q <= cnt_q + (PTR_W+1)'(CMD_I[6] ? 2 : 1);
    end else if (ARRAY_WR_I) begin
      occ_q[ARRAY_ADDR_I] <= ARRAY_OCC_I;
      if (ARRAY_OCC_I && !occ_q[ARRAY_ADDR_I]) begin
        cnt_q <= cnt_q + (PTR_W+1)'(1);
      end else if (!ARRAY_OCC_I && occ_q[ARRAY_ADDR_I]) begin
        cnt_q <= cnt_q - (PTR_W+1)'(1);
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      full_q <= 1'b0;
    end else begin
      full_q <= (cnt_q == (PTR_W+1)'(DEPTH));
    end
  end

  // the scan steps one slot a cycle (two after a 136-bit learn), so a learn issued mid-scan on a taken
  // slot is dropped; back-to-back learns normally land on a free neighbour
  wire [PTR_W-1:0] sb = wide_q ? {free_q[PTR_W-1:1], 1'b0} : free_q;
  wire sb_busy = occ_q[sb] || (wide_q && occ_q[{sb[PTR_W-1:1], 1'b1}]);
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      free_q <= '0;
      wide_q <= 1'b0;
      scan_q <= lca_pkg::LCA_IDLE;
    end else if (win_learn) begin
      wide_q <= CMD_I[6];
      scan_q <= lca_pkg::LCA_SCAN;
    end else if (ARRAY_WR_I) begin
      if (!ARRAY_OCC_I && ARRAY_ADDR_I < free_q) begin
        free_q <= ARRAY_ADDR_I;
      end
      scan_q <= lca_pkg::LCA_SCAN;
    end else begin
      case (scan_q)
        lca_pkg::LCA_SCAN: begin
          // live count: full_q lags a clear by one cycle and would stop the scan early
          if (cnt_q == (PTR_W+1)'(DEPTH) || !sb_busy) begin
            scan_q <= lca_pkg::LCA_IDLE;
          end else begin
            free_q <= sb + PTR_W'(wide_q ? 2 : 1);
          end
        end
        default: scan_q <= lca_pkg::LCA_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      CAM_WR_O <= 1'b0;
      CAM_ADDR_O <= '0;
      CAM_PAIR_O <= 4'h0;
      CAM_WIDE_O <= 1'b0;
    end else begin
      CAM_WR_O <= win_learn;
      CAM_ADDR_O <= base;
      CAM_PAIR_O <= pair_q;
      CAM_WIDE_O <= CMD_I[6];
    end
  end

  // command pipeline, index k means k cycles after the second command cycle
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      li_q <= '0;
      lw_q <= '0;
      sp_q <= '0;
    end else begin
      li_q <= {li_q[5:1], learn2};
      lw_q <= {lw_q[5:1], win_learn};
      sp_q <= {sp_q[5:1], srch2};
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      for (int k = 1; k <= 6; k++) begin
        cp_q[k] <= 3'h0;
        lad_q[k] <= '0;
      end
    end else begin
      cp_q[1] <= csel_q;
      lad_q[1] <= base;
      for (int k = 2; k <= 6; k++) begin
        cp_q[k] <= cp_q[k-1];
        lad_q[k] <= lad_q[k-1];
      end
    end
  end

  // own result, then the upstream view one cycle later
  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      hit_q <= 1'b0;
      idx_q <= '0;
      uhit_q <= 1'b0;
      LOCAL_HIT_OUT_O <= 2'h0;
      BLOCK_HIT_OUT_O <= 3'h0;
    end else begin
      if (sp_q[lca_pkg::HIT_STAGE]) begin
        hit_q <= SEARCH_HIT_I;
        idx_q <= SEARCH_INDEX_I;
      end
      LOCAL_HIT_OUT_O <= sp_q[lca_pkg::HIT_STAGE] ? {2{SEARCH_HIT_I}} : 2'h0;
      if (sp_q[lca_pkg::ARB_STAGE]) begin
        uhit_q <= |LOCAL_HIT_IN_I;
      end
      BLOCK_HIT_OUT_O <= (sp_q[lca_pkg::ARB_STAGE] && last) ?
        {3{hit_q || (|LOCAL_HIT_IN_I)}} : 3'h0;
    end
  end

  wire dl = li_q[lm1];
  wire dw = lw_q[lm1];
  wire ds = sp_q[lm1];
  wire own = (tsize == lca_pkg::TSIZE_ONE) ? SEARCH_HIT_I : hit_q;
  wire [PTR_W-1:0] oidx = (tsize == lca_pkg::TSIZE_ONE) ? SEARCH_INDEX_I : idx_q;
  wire up = (tsize == lca_pkg::TSIZE_BLK) ? (|LOCAL_HIT_IN_I) :
            (tsize == lca_pkg::TSIZE_ONE) ? 1'b0 : uhit_q;
  wire [lca_pkg::ID_W-1:0] id_f = dev_id;

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      MEM_BUS_OE_O <= 1'b0;
      MEM_CE_N_O <= 1'b1;
      MEM_WE_N_O <= 1'b1;
      MEMORY_ADDRESS_BUS_O <= '0;
    end else begin
      MEM_BUS_OE_O <= dflt;
      MEM_CE_N_O <= 1'b1;
      MEM_WE_N_O <= 1'b1;
      MEMORY_ADDRESS_BUS_O <= '0;
      if (dl) begin
        if (dw) begin
          MEM_BUS_OE_O <= 1'b1;
          MEM_CE_N_O <= 1'b0;
          MEM_WE_N_O <= 1'b0;
          MEMORY_ADDRESS_BUS_O <= {cp_q[lm1], id_f, {PAD{1'b0}}, lad_q[lm1]};
        end else begin
          MEM_BUS_OE_O <= dflt && tfull;
        end
      end else if (ds) begin
        if (own && !up) begin
          MEM_BUS_OE_O <= 1'b1;
          MEM_CE_N_O <= 1'b0;
          MEMORY_ADDRESS_BUS_O <= {cp_q[lm1], id_f, {PAD{1'b0}}, oidx};
        end else begin
          MEM_BUS_OE_O <= dflt && !up && !own;
        end
      end
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      MEM_OE_N_O <= 1'b0;
    end else begin
      MEM_OE_N_O <= li_q[lm2] || li_q[lm1];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      RESULT_FLAG_OE_O <= 1'b0;
      RESULT_VALID_FLAG_O <= 1'b0;
      HIT_FLAG_O <= 1'b0;
    end else if (ds) begin
      RESULT_FLAG_OE_O <= (own && !up) || (last && !up && !own);
      RESULT_VALID_FLAG_O <= 1'b1;
      HIT_FLAG_O <= own && !up;
    end else begin
      RESULT_FLAG_OE_O <= last;
      RESULT_VALID_FLAG_O <= 1'b0;
      HIT_FLAG_O <= 1'b0;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (RST_I) begin
      cfg_q <= lca_pkg::CFG_RST;
      REG_RDATA_O <= 32'h0;
    end else begin
      if (REG_WR_I && REG_ADDR_I == lca_pkg::REG_CFG) begin
        cfg_q <= REG_WDATA_I[lca_pkg::CFG_W-1:0];
      end
      REG_RDATA_O <= 32'h0;
      if (REG_RD_I && REG_ADDR_I == lca_pkg::REG_CFG) begin
        REG_RDATA_O <= {24'h0, cfg_q};
      end else if (REG_RD_I && REG_ADDR_I == lca_pkg::REG_STAT) begin
        REG_RDATA_O[PTR_W-1:0] <= free_q;
        REG_RDATA_O[lca_pkg::STAT_FULL_BIT] <= full_q;
        REG_RDATA_O[lca_pkg::STAT_SCAN_BIT] <= (scan_q == lca_pkg::LCA_SCAN);
      end
    end
  end

  assign FULL_OUT_O = {2{full_q}};
  assign TABLE_FULL_O = tfull;
  assign BLOCK_HIT_OE_O = last;
  assign MEM_OE_N_OE_O = dflt;

  sequence s_learn_one;
    learn2 && win_learn && tsize == lca_pkg::TSIZE_ONE;
  endsequence
  sequence s_write_cycle;
    MEM_BUS_OE_O && !MEM_CE_N_O && !MEM_WE_N_O;
  endsequence
  property p_full_out;
    @(posedge CLK_I) disable iff (RST_I) (cnt_q == (PTR_W+1)'(DEPTH)) |=> FULL_OUT_O == 2'h3;
  endproperty
  a_full_out: assert property (p_full_out) else $error("full-out not raised");
  property p_one_learner;
    @(posedge CLK_I) disable iff (RST_I) (learn2 && !FULL_IN_I) |=> !CAM_WR_O;
  endproperty
  a_one_learner: assert property (p_one_learner) else $error("learn despite upstream");
  property p_all_full;
    @(posedge CLK_I) disable iff (RST_I) (learn2 && full_q) |=> !CAM_WR_O;
  endproperty
  a_all_full: assert property (p_all_full) else $error("learn while full");
  property p_pair_even;
    @(posedge CLK_I) disable iff (RST_I) (CAM_WR_O && CAM_WIDE_O) |-> !CAM_ADDR_O[0];
  endproperty
  a_pair_even: assert property (p_pair_even) else $error("odd pair base");
  property p_write_lat;
    @(posedge CLK_I) disable iff (RST_I) s_learn_one |-> ##4 s_write_cycle;
  endproperty
  a_write_lat: assert property (p_write_lat) else $error("write cycle late");
  property p_oe_two;
    @(posedge CLK_I) disable iff (RST_I)
      (learn2 && tsize == lca_pkg::TSIZE_BLK) |-> ##4 MEM_OE_N_O [*2];
  endproperty
  a_oe_two: assert property (p_oe_two) else $error("oe pin not high twice");
  property p_lho;
    @(posedge CLK_I) disable iff (RST_I) (srch2 ##3 SEARCH_HIT_I) |=> LOCAL_HIT_OUT_O == 2'h3;
  endproperty
  a_lho: assert property (p_lho) else $error("local hit not driven");
  property p_defer;
    @(posedge CLK_I) disable iff (RST_I)
      (sp_q[4] && (|LOCAL_HIT_IN_I) && tsize == lca_pkg::TSIZE_BLK && !dl) |=> !MEM_BUS_OE_O;
  endproperty
  a_defer: assert property (p_defer) else $error("bus driven after upstream hit");
  property p_last_flags;
    @(posedge CLK_I) disable iff (RST_I) (last && !ds) |=> RESULT_FLAG_OE_O && !RESULT_VALID_FLAG_O;
  endproperty
  a_last_flags: assert property (p_last_flags) else $error("flags not driven");
endmodule

/* hdl/lca_pkg.sv */
// Purpose: shared constants for the learn and cascade arbitration block
// Assumes: 100 MHz core clock, register port with 4-bit byte address
// Notes: latencies are counted in core clock cycles from the second command cycle
package lca_pkg;
  // command opcodes on the two low command bits
  localparam logic [1:0] OP_SEARCH = 2'h2;
  localparam logic [1:0] OP_LEARN = 2'h3;
  localparam int CMD_W = 9;
  // table size field encodings
  localparam logic [1:0] TSIZE_ONE = 2'h0;
  localparam logic [1:0] TSIZE_BLK = 2'h1;
  localparam logic [1:0] TSIZE_MULTI = 2'h2;
  // memory cycle latency for each table size
  localparam logic [2:0] LAT_ONE = 3'h4;
  localparam logic [2:0] LAT_BLK = 3'h5;
  localparam logic [2:0] LAT_MULTI = 3'h6;
  // stage at which the own search result is known and local hits go out, then the stage at which upstream hits are arbitrated
  localparam int HIT_STAGE = 3;
  localparam int ARB_STAGE = 4;
  // memory address layout
  localparam int MEM_ADDR_W = 22;
  localparam int IDX_W = 15;
  localparam int ID_W = 4;
  // register map
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int CFG_TSIZE_LSB = 0;
  localparam int CFG_DFLT_BIT = 2;
  localparam int CFG_LAST_BIT = 3;
  localparam int CFG_ID_LSB = 4;
  localparam int CFG_W = 8;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam int STAT_FULL_BIT = 16;
  localparam int STAT_SCAN_BIT = 17;
  typedef enum logic {LCA_IDLE, LCA_SCAN} lca_scan_t;
endpackage

/* tb/lca_host_model.sv */
// Purpose: host controller and upstream cascade neighbours facing the learn block
// Assumes: shares the core clock; every change lands just after a rising edge
// Notes: released command lines show the inverse of their last value
`timescale 1ns/1ps
module lca_host_model (
  // clock
  input wire logic clk_i,
  // host command port
  output logic [lca_pkg::CMD_W-1:0] cmd_o,
  output logic cmd_valid_o,
  // upstream neighbours
  output logic full_in_o,
  output logic [6:0] up_hit_o
);
  initial begin
    cmd_o = '0;
    cmd_valid_o = 1'b0;
    full_in_o = 1'b1;
    up_hit_o = 7'h00;
  end

  task automatic issue(input logic [1:0] op, input logic [3:0] pair, input logic [2:0] hi,
                       input logic wide);
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    cmd_o <= {hi, pair, op};
    @(posedge clk_i);
    cmd_o <= {hi[2:1], wide, pair, op};
    @(posedge clk_i);
    cmd_valid_o <= 1'b0;
    cmd_o <= ~cmd_o;
  endtask

  // upstream fullness and hits as seen at this device's chain inputs
  task automatic set_up(input logic full, input logic [6:0] hits);
    @(posedge clk_i);
    full_in_o <= full;
    up_hit_o <= hits;
  endtask
endmodule

/* tb/testbench.sv */
// Purpose: self-checking bench for learn, fullness chain and cascade arbitration
// Assumes: four-entry table so that filling it takes only a few learns
// Notes: cycle n counts edges after the second command cycle
`timescale 1ns/1ps
module testbench;
  localparam int PW = 2;
  logic clk, rst, cmd_v, full_in, reg_wr, reg_rd, arr_wr, arr_occ, s_hit;
  logic [lca_pkg::CMD_W-1:0] cmd;
  logic [6:0] up_hit;
  logic [3:0] reg_addr, cam_pair;
  logic [31:0] reg_wdata, reg_rdata, rd;
  logic [PW-1:0] arr_addr, s_idx, cam_addr;
  logic cam_wr, cam_wide, table_full, blk_hit_oe, ce_n, we_n, bus_oe, oe_n, oe_n_oe, rv, hf, rf_oe;
  logic [1:0] full_out, hit_out;
  logic [2:0] blk_hit;
  logic [21:0] mem_addr;
  int miscompares, n_checks, cyc;

  lca_host_model host_u (.clk_i(clk), .cmd_o(cmd), .cmd_valid_o(cmd_v), .full_in_o(full_in),
    .up_hit_o(up_hit));

  lca_learn_cascade #(.PTR_W(PW)) dut_u (.CLK_I(clk), .RST_I(rst), .CMD_I(cmd),
    .COMMAND_VALID_I(cmd_v), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata), .REG_WR_I(reg_wr),
    .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .ARRAY_WR_I(arr_wr), .ARRAY_ADDR_I(arr_addr),
    .ARRAY_OCC_I(arr_occ), .SEARCH_HIT_I(s_hit), .SEARCH_INDEX_I(s_idx), .CAM_WR_O(cam_wr),
    .CAM_ADDR_O(cam_addr), .CAM_PAIR_O(cam_pair), .CAM_WIDE_O(cam_wide), .FULL_IN_I(full_in),
    .FULL_OUT_O(full_out), .TABLE_FULL_O(table_full), .LOCAL_HIT_IN_I(up_hit),
    .LOCAL_HIT_OUT_O(hit_out), .BLOCK_HIT_OUT_O(blk_hit), .BLOCK_HIT_OE_O(blk_hit_oe),
    .MEMORY_ADDRESS_BUS_O(mem_addr), .MEM_CE_N_O(ce_n), .MEM_WE_N_O(we_n),
    .MEM_BUS_OE_O(bus_oe), .MEM_OE_N_O(oe_n), .MEM_OE_N_OE_O(oe_n_oe),
    .RESULT_VALID_FLAG_O(rv), .HIT_FLAG_O(hf), .RESULT_FLAG_OE_O(rf_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_of_test();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // the whole run needs well under a thousand cycles
  initial begin
    #20000;
    miscompares++;
    $display("Error watchdog expected finish seen hang");
    end_of_test();
  end

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic reg_wr_t(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_rd_t(input logic [3:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask

  // address high bits track the width bit so both command cycles agree on them
  task automatic cmd_t(input logic [1:0] op, input logic wide);
    host_u.issue(op, 4'h9, {2'h2, wide}, wide);
    cyc = 1;
  endtask

  task automatic upto(input int n);
    while (cyc < n) begin
      @(posedge clk);
      cyc++;
    end
    #1;
  endtask

  task automatic learn_ok(input logic wide, input logic [PW-1:0] ent, input int lat);
    cmd_t(lca_pkg::OP_LEARN, wide);
    upto(1);
    chk("cam_wr", cam_wr, 1);
    chk("cam_addr", cam_addr, ent);
    chk("cam_wide", cam_wide, wide);
    chk("cam_pair", cam_pair, 4'h9);
    upto(lat - 1);
    chk("oe_n", oe_n, 1);
    chk("we_n", we_n, 1);
    upto(lat);
    chk("oe_n", oe_n, 1);
    chk("bus_oe", bus_oe, 1);
    chk("oe_n_oe", oe_n_oe, 1);
    chk("ce_we", {ce_n, we_n}, 2'b00);
    chk("mem_addr", mem_addr, {2'h2, wide, 4'h5, 15'(ent)});
    upto(lat + 1);
    chk("oe_n", oe_n, 0);
    chk("we_n", we_n, 1);
    repeat (8) @(posedge clk);
  endtask

  task automatic learn_no(input int lat, input logic exp_oe);
    cmd_t(lca_pkg::OP_LEARN, 1'b0);
    upto(1);
    chk("cam_wr", cam_wr, 0);
    upto(lat);
    chk("we_n", we_n, 1);
    chk("oe_n", oe_n, 1);
    chk("bus_oe", bus_oe, exp_oe);
    repeat (8) @(posedge clk);
  endtask

  task automatic at_lat(input logic own, input logic [6:0] up);
    if (up != 7'h00) begin
      chk("bus_oe", bus_oe, 0);
      chk("rf_oe", rf_oe, 0);
    end else if (own) begin
      chk("ce_we", {bus_oe, ce_n, we_n}, 3'b101);
      chk("mem_addr", mem_addr, {3'h4, 4'h5, 15'h2});
      chk("flags", {rf_oe, rv, hf}, 3'b111);
    end else begin
      chk("bus_oe", bus_oe, 1);
      chk("flags", {rf_oe, rv, hf}, 3'b110);
    end
  endtask

  task automatic search_t(input logic own, input logic [6:0] up, input int lat);
    s_hit <= own;
    s_idx <= 2'h2;
    host_u.set_up(1'b1, up);
    cmd_t(lca_pkg::OP_SEARCH, 1'b0);
    upto(4);
    chk("hit_out", hit_out, {own, own});
    if (lat == 4) at_lat(own, up);
    upto(5);
    chk("hit_out", hit_out, 0);
    chk("blk_hit", blk_hit, (own || up != 7'h00) ? 3'h7 : 3'h0);
    chk("blk_hit_oe", blk_hit_oe, 1);
    if (lat == 5) at_lat(own, up);
    upto(6);
    if (lat == 6) at_lat(own, up);
    host_u.set_up(1'b1, 7'h00);
    s_hit <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic clear_t();
    @(posedge clk);
    arr_wr <= 1'b1;
    arr_addr <= 2'h1;
    arr_occ <= 1'b0;
    @(posedge clk);
    arr_wr <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("full_out", full_out, 0);
    reg_rd_t(lca_pkg::REG_STAT);
    chk("stat", rd, 32'h1);
    // refill the cleared slot the way software marks entries taken
    @(posedge clk);
    arr_wr <= 1'b1;
    arr_occ <= 1'b1;
    @(posedge clk);
    arr_wr <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("full_out", full_out, 2'b11);
  endtask

  initial begin
    {rst, reg_wr, reg_rd, arr_wr, arr_occ, s_hit} = 6'h21;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    arr_addr = 2'h0;
    s_idx = 2'h0;
    miscompares = 0;
    n_checks = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_rd_t(lca_pkg::REG_CFG);
    chk("cfg", rd, 32'h0);
    reg_wr_t(lca_pkg::REG_STAT, 32'hffff);
    reg_rd_t(lca_pkg::REG_STAT);
    chk("stat", rd, 32'h0);
    reg_rd_t(4'h8);
    chk("unmapped", rd, 32'h0);
    reg_wr_t(lca_pkg::REG_CFG, 32'h5c);
    reg_rd_t(lca_pkg::REG_CFG);
    chk("cfg", rd, 32'h5c);
    host_u.set_up(1'b0, 7'h00);
    learn_no(4, 1'b0);
    host_u.set_up(1'b1, 7'h00);
    reg_wr_t(lca_pkg::REG_CFG, 32'h5d);
    learn_ok(1'b1, 2'h0, 5);
    reg_rd_t(lca_pkg::REG_STAT);
    chk("stat", rd, 32'h2);
    reg_wr_t(lca_pkg::REG_CFG, 32'h5e);
    learn_ok(1'b0, 2'h2, 6);
    reg_wr_t(lca_pkg::REG_CFG, 32'h5c);
    learn_ok(1'b0, 2'h3, 4);
    #1;
    chk("full_out", full_out, 2'b11);
    chk("table_full", table_full, 1);
    reg_rd_t(lca_pkg::REG_STAT);
    chk("stat_full", rd[16], 1);
    learn_no(4, 1'b1);
    host_u.set_up(1'b0, 7'h00);
    #1;
    chk("table_full", table_full, 0);
    host_u.set_up(1'b1, 7'h00);
    clear_t();
    search_t(1'b1, 7'h00, 4);
    search_t(1'b0, 7'h00, 4);
    reg_wr_t(lca_pkg::REG_CFG, 32'h5d);
    search_t(1'b1, 7'h01, 5);
    reg_wr_t(lca_pkg::REG_CFG, 32'h5e);
    search_t(1'b0, 7'h01, 6);
    end_of_test();
  end
endmodule
